// ===== core/swc_sleep_wake.sv
// Sleep entry, wake-up and peripheral request flag registers.
`timescale 1ns/1ps
module swc_sleep_wake
	import swc_pkg::*;
#(
	parameter int PIN_COUNT = 6
) (
	// Clock and reset
	input  wire logic                 MCLK,
	input  wire logic                 RESET,
	// Register port
	input  wire logic [3:0]           ADDR,
	input  wire logic [7:0]           WDATA,
	input  wire logic                 WR,
	input  wire logic                 RD,
	output logic      [7:0]           RDATA,
	// Core interface
	input  wire logic                 SLEEP_EXEC,
	input  wire logic                 CLRWDT_EXEC,
	input  wire logic [15:0]          PC,
	output logic      [15:0]          PREFETCH_PC,
	output logic                      CORE_CLK_EN,
	output logic                      WAKE_CONTINUE,
	output logic                      SERVICE_IRQ,
	output logic                      REGULATOR_LOW,
	// Watchdog and oscillators
	input  wire logic                 WDT_TICK,
	output logic                      WDT_TIMEOUT,
	output logic                      LF_OSC_RUN,
	output logic                      SENSE_OSC_RUN,
	input  wire logic                 TIMER1_SLEEP_CLK,
	output logic                      TIMER1_RUN,
	input  wire logic                 CONV_RC_CLK_SEL,
	output logic                      CONV_RUN,
	// Peripheral sources: SRC1 and SRC2 one-cycle events, RX and TX pending levels
	input  wire logic [7:0]           SRC1,
	input  wire logic [7:0]           SRC2,
	input  wire logic                 RX_PENDING,
	input  wire logic                 TX_PENDING,
	// Pin drive
	input  wire logic [PIN_COUNT-1:0] PIN_OUT_CORE,
	input  wire logic [PIN_COUNT-1:0] PIN_OE_N_CORE,
	output logic      [PIN_COUNT-1:0] PIN_OUT,
	output logic      [PIN_COUNT-1:0] PIN_OE_N
);

	// Refuse a pin count that leaves the freeze registers without bits.
	if (PIN_COUNT < 1) begin : g_bad_pin_count
		$error("PIN_COUNT must be at least one");
	end

	// =================================================================
	// State
	swc_state_e            state;
	logic [7:0]            flags1;
	logic [7:0]            flags2;
	logic [7:0]            enable1;
	logic [7:0]            enable2;
	logic [7:0]            control;
	logic                  timeout;
	logic                  power_down;
	logic [WDT_WIDTH-1:0]  wdt_count;
	logic                  wake_req;
	logic                  sleep_taken;
	logic                  wdt_run;
	logic                  wdt_expire;

	function automatic logic masked_any(input logic [7:0] f, input logic [7:0] e);
		return |(f & e);
	endfunction

	// Peripheral pairs count only with the peripheral enable set.
	assign wake_req = control[CTL_PERIPH_EN] &
		(masked_any(flags1, enable1) | masked_any(flags2, enable2 & FLAGS2_MASK));
	assign sleep_taken = (state == SWC_AWAKE) && SLEEP_EXEC && !wake_req;
	assign wdt_run = (state != SWC_ASLEEP) || control[CTL_WDT_SLEEP];
	assign wdt_expire = WDT_TICK && wdt_run && (&wdt_count);

	// =================================================================
	// Request flags: set wins over a software clear.
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			flags1 <= FLAGS_RESET;
		end else begin
			logic [7:0] v;
			v = flags1;
			if (WR && ADDR == ADDR_FLAGS1) begin
				v = (v & ~FLAGS1_WMASK) | (WDATA & FLAGS1_WMASK);
			end
			v = v | SRC1;
			v[5] = RX_PENDING;
			v[4] = TX_PENDING;
			flags1 <= v;
		end
	end

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			flags2 <= FLAGS_RESET;
		end else if (WR && ADDR == ADDR_FLAGS2) begin
			flags2 <= (WDATA | SRC2) & FLAGS2_MASK;
		end else begin
			flags2 <= (flags2 | SRC2) & FLAGS2_MASK;
		end
	end

	// =================================================================
	// Enables and control.
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			enable1 <= FLAGS_RESET;
			enable2 <= FLAGS_RESET;
			control <= CONTROL_RESET;
		end else if (WR) begin
			if (ADDR == ADDR_ENABLE1) enable1 <= WDATA;
			if (ADDR == ADDR_ENABLE2) enable2 <= WDATA & FLAGS2_MASK;
			if (ADDR == ADDR_CONTROL) control <= WDATA;
		end
	end

	// =================================================================
	// Sleep sequencer.
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			state <= SWC_AWAKE;
		end else begin
			case (state)
				SWC_AWAKE: begin
					if (sleep_taken) state <= SWC_ASLEEP;
				end
				SWC_ASLEEP: begin
					if (wake_req || wdt_expire) state <= SWC_WAKING;
				end
				SWC_WAKING: begin
					state <= SWC_AWAKE;
				end
				default: state <= SWC_AWAKE;
			endcase
		end
	end

	// Status flags: reset shows timeout and power-down set.
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			timeout    <= 1'b1;
			power_down <= 1'b1;
		end else if (sleep_taken) begin
			timeout    <= 1'b1;
			power_down <= 1'b0;
		end else if (state == SWC_ASLEEP && wdt_expire) begin
			timeout    <= 1'b0;
		end else if (CLRWDT_EXEC && state == SWC_AWAKE) begin
			timeout    <= 1'b1;
			power_down <= 1'b1;
		end
	end

	// Watchdog counter: cleared on entry and on every wake.
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			wdt_count <= '0;
		end else if (sleep_taken || state == SWC_WAKING || CLRWDT_EXEC) begin
			wdt_count <= '0;
		end else if (WDT_TICK && wdt_run) begin
			wdt_count <= wdt_count + 1'b1;
		end
	end

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			WDT_TIMEOUT <= 1'b0;
		end else begin
			// Awake expiry resets the device; asleep it only wakes.
			WDT_TIMEOUT <= wdt_expire && state == SWC_AWAKE;
		end
	end

	// =================================================================
	// Core-facing outputs.
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			CORE_CLK_EN   <= 1'b1;
			PREFETCH_PC   <= 16'h0000;
			WAKE_CONTINUE <= 1'b0;
			SERVICE_IRQ   <= 1'b0;
			REGULATOR_LOW <= 1'b0;
		end else begin
			CORE_CLK_EN   <= !(sleep_taken || state == SWC_ASLEEP) ||
				(state == SWC_ASLEEP && (wake_req || wdt_expire));
			if (SLEEP_EXEC && state == SWC_AWAKE) PREFETCH_PC <= PC + 16'h0001;
			WAKE_CONTINUE <= state == SWC_WAKING;
			SERVICE_IRQ   <= state == SWC_WAKING && wake_req && control[CTL_GLOBAL_EN];
			REGULATOR_LOW <= (sleep_taken || state == SWC_ASLEEP) &&
				!(state == SWC_ASLEEP && (wake_req || wdt_expire)) &&
				control[CTL_LOW_POWER];
		end
	end

	// Oscillator and sleep-capable peripheral run enables.
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			LF_OSC_RUN    <= 1'b1;
			SENSE_OSC_RUN <= 1'b1;
			TIMER1_RUN    <= 1'b1;
			CONV_RUN      <= 1'b1;
		end else begin
			LF_OSC_RUN    <= 1'b1;
			SENSE_OSC_RUN <= 1'b1;
			TIMER1_RUN    <= state != SWC_ASLEEP || TIMER1_SLEEP_CLK;
			CONV_RUN      <= state != SWC_ASLEEP || CONV_RC_CLK_SEL;
		end
	end

	// Pins freeze in whatever drive they had at sleep entry.
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			PIN_OUT  <= '0;
			PIN_OE_N <= '1;
		end else if (state == SWC_AWAKE && !sleep_taken) begin
			PIN_OUT  <= PIN_OUT_CORE;
			PIN_OE_N <= PIN_OE_N_CORE;
		end
	end

	// =================================================================
	// Register read port.
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			RDATA <= 8'h00;
		end else if (RD) begin
			case (ADDR)
				ADDR_FLAGS1:  RDATA <= flags1;
				ADDR_FLAGS2:  RDATA <= flags2 & FLAGS2_MASK;
				ADDR_ENABLE1: RDATA <= enable1;
				ADDR_ENABLE2: RDATA <= enable2;
				ADDR_CONTROL: RDATA <= control;
				ADDR_STATUS:  RDATA <= {3'h0, timeout, power_down, 2'h0,
					state == SWC_ASLEEP};
				default:      RDATA <= 8'h00;
			endcase
		end else begin
			RDATA <= 8'h00;
		end
	end

endmodule // swc_sleep_wake

// ===== core/swc_pkg.sv
// Constants shared by the sleep and wake controller.
// =====================================================================
// What this block does
// - Source events set flags regardless of enables.
// - First flag register holds eight peripheral flags.
// - Receive and transmit flags are read-only.
// - Second register holds four flags, rest zero.
// - Sleep entered only by sleep instruction.
// - Entry clears power-down, sets timeout, gates clock.
// - Entry clears watchdog; runs only if configured.
// - Low-frequency oscillator keeps running in sleep.
// - Timer1 runs in sleep on sleep-capable clocks.
// - Converter on RC clock and sensing oscillator run.
// - Pins hold their drive state while asleep.
// - Pin, brown-out and power-on resets still act.
// - Hard resets restart; other wakes continue execution.
// - Sleep instruction prefetches program counter plus one.
// - Interrupt wakes only with its own enable.
// - After wake, run prefetched op, then maybe service.
// - Watchdog cleared on every wake.
// - Pending enabled flag makes sleep a no-operation.
// - Flag during sleep instruction completes then wakes.
// - Low-power select puts regulator low in sleep.
// - Peripheral flags need peripheral enable too.
package swc_pkg;

	// =================================================================
	// Register map
	localparam logic [3:0] ADDR_FLAGS1  = 4'h0;
	localparam logic [3:0] ADDR_FLAGS2  = 4'h1;
	localparam logic [3:0] ADDR_ENABLE1 = 4'h2;
	localparam logic [3:0] ADDR_ENABLE2 = 4'h3;
	localparam logic [3:0] ADDR_CONTROL = 4'h4;
	localparam logic [3:0] ADDR_STATUS  = 4'h5;

	// =================================================================
	// Field layout
	localparam logic [7:0] FLAGS1_WMASK = 8'hcf;
	localparam logic [7:0] FLAGS2_MASK  = 8'hb8;
	localparam logic [7:0] FLAGS_RESET  = 8'h00;
	localparam int CTL_GLOBAL_EN  = 7;
	localparam int CTL_PERIPH_EN  = 6;
	localparam int CTL_LOW_POWER  = 1;
	localparam int CTL_WDT_SLEEP  = 0;
	localparam int STS_TIMEOUT    = 4;
	localparam int STS_POWER_DOWN = 3;
	localparam int STS_ASLEEP     = 0;
	localparam logic [7:0] CONTROL_RESET = 8'h00;

	// =================================================================
	// Timing
	localparam int WDT_WIDTH = 16;

	typedef enum logic [1:0] {
		SWC_AWAKE = 2'b00,
		SWC_ASLEEP = 2'b01,
		SWC_WAKING = 2'b10
	} swc_state_e;

endpackage

// ===== sim/swc_monitor.sv
// Port checker of sleep entry, wake-up and pin freeze.
`timescale 1ns/1ps
module swc_monitor
	import swc_pkg::*;
#(
	parameter int PIN_COUNT = 6
) (
	// Clock and reset
	input wire logic                 MCLK,
	input wire logic                 RESET,
	// Core side
	input wire logic                 SLEEP_EXEC,
	input wire logic [15:0]          PC,
	input wire logic [15:0]          PREFETCH_PC,
	input wire logic                 CORE_CLK_EN,
	input wire logic                 WAKE_CONTINUE,
	input wire logic                 SERVICE_IRQ,
	input wire logic                 REGULATOR_LOW,
	// Oscillators and pins
	input wire logic                 LF_OSC_RUN,
	input wire logic                 SENSE_OSC_RUN,
	input wire logic                 TIMER1_SLEEP_CLK,
	input wire logic                 TIMER1_RUN,
	input wire logic                 CONV_RC_CLK_SEL,
	input wire logic                 CONV_RUN,
	input wire logic [PIN_COUNT-1:0] PIN_OUT,
	input wire logic [PIN_COUNT-1:0] PIN_OE_N
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RESET);
	// =================================================================
	// Assertions
	sleep_entry_a: assert property ($fell(CORE_CLK_EN) |-> $past(SLEEP_EXEC))
		else $error("core clock stopped without a sleep request");
	prefetch_pc_a: assert property (SLEEP_EXEC && CORE_CLK_EN |=>
		PREFETCH_PC == $past(PC) + 16'h1) else $error("prefetch address wrong");
	service_pair_a: assert property (SERVICE_IRQ |-> WAKE_CONTINUE)
		else $error("service request without wake pulse");
	wake_pulse_a: assert property ($rose(CORE_CLK_EN) |=> WAKE_CONTINUE)
		else $error("wake without continue pulse");
	pins_hold_a: assert property (!CORE_CLK_EN && $past(!CORE_CLK_EN) |->
		$stable(PIN_OUT) && $stable(PIN_OE_N)) else $error("pins moved in sleep");
	regulator_low_a: assert property (REGULATOR_LOW |-> !CORE_CLK_EN)
		else $error("regulator low while awake");
	osc_run_a: assert property (LF_OSC_RUN && SENSE_OSC_RUN)
		else $error("oscillator stopped");
	timer_run_a: assert property (!TIMER1_RUN |-> !$past(TIMER1_SLEEP_CLK))
		else $error("timer stopped on a sleep clock");
	conv_run_a: assert property (!CONV_RUN |-> !$past(CONV_RC_CLK_SEL))
		else $error("converter stopped on its own clock");
	cover property ($fell(CORE_CLK_EN));
	cover property (SERVICE_IRQ);
	cover property (REGULATOR_LOW);
endmodule // swc_monitor

bind swc_sleep_wake swc_monitor #(.PIN_COUNT(PIN_COUNT)) i_swc_monitor (
	.MCLK(MCLK), .RESET(RESET), .SLEEP_EXEC(SLEEP_EXEC), .PC(PC),
	.PREFETCH_PC(PREFETCH_PC), .CORE_CLK_EN(CORE_CLK_EN), .WAKE_CONTINUE(WAKE_CONTINUE),
	.SERVICE_IRQ(SERVICE_IRQ), .REGULATOR_LOW(REGULATOR_LOW), .LF_OSC_RUN(LF_OSC_RUN),
	.SENSE_OSC_RUN(SENSE_OSC_RUN), .TIMER1_SLEEP_CLK(TIMER1_SLEEP_CLK),
	.TIMER1_RUN(TIMER1_RUN), .CONV_RC_CLK_SEL(CONV_RC_CLK_SEL), .CONV_RUN(CONV_RUN),
	.PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N)
);

// ===== sim/swc_core_model.sv
// Core and peripheral model on the far side of the controller.
`timescale 1ns/1ps
module swc_core_model
	import swc_pkg::*;
#(
	parameter int PIN_COUNT = 6
) (
	// Clock
	input  wire logic            MCLK,
	// Core requests
	output logic                 SLEEP_EXEC = 1'h0,
	output logic                 CLRWDT_EXEC = 1'h0,
	output logic [15:0]          PC = 16'h0,
	// Peripheral events and pins
	output logic [7:0]           SRC1 = 8'h0,
	output logic [7:0]           SRC2 = 8'h0,
	output logic [PIN_COUNT-1:0] PIN_OUT_CORE = '0,
	output logic [PIN_COUNT-1:0] PIN_OE_N_CORE = '1
);
	// Pins change every cycle so that a freeze in sleep is visible.
	always @(posedge MCLK) begin
		PIN_OUT_CORE <= PIN_OUT_CORE + 1'h1;
		PIN_OE_N_CORE <= ~PIN_OUT_CORE;
	end
	task automatic sleep(logic [15:0] p);
		@(posedge MCLK);
		PC <= p;
		SLEEP_EXEC <= 1'h1;
		@(posedge MCLK);
		SLEEP_EXEC <= 1'h0;
	endtask
	task automatic fire(logic [7:0] a, logic [7:0] b);
		@(posedge MCLK);
		SRC1 <= a;
		SRC2 <= b;
		@(posedge MCLK);
		SRC1 <= 8'h0;
		SRC2 <= 8'h0;
	endtask
	task automatic clrwdt();
		@(posedge MCLK);
		CLRWDT_EXEC <= 1'h1;
		@(posedge MCLK);
		CLRWDT_EXEC <= 1'h0;
	endtask
endmodule // swc_core_model

// ===== sim/testbench.sv
// Self-checking bench of the sleep and wake controller.
`timescale 1ns/1ps
module testbench;
	import swc_pkg::*;
	logic        mclk = 0, reset = 1, wr = 0, rd = 0, rx = 0, tx = 0, t1_sel = 0, rc_sel = 0;
	logic        tick = 0;
	logic [3:0]  addr = 4'h0;
	logic [7:0]  wdata = 8'h0, rdata, src1, src2, s1, s2;
	logic [15:0] pc_bus, ppc, pc;
	logic [5:0]  pin_oc, pin_oec;
	logic        sleep_exec, clrwdt, clk_en, wake, svc;
	int          fail_count = 0, check_count = 0, seed = 47054, i;
	logic [15:0] cfg [2] = '{16'h4002, 16'h8001};
	always #20 mclk = ~mclk;
	swc_sleep_wake i_swc_sleep_wake (.MCLK(mclk), .RESET(reset), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .SLEEP_EXEC(sleep_exec), .CLRWDT_EXEC(clrwdt),
		.PC(pc_bus), .PREFETCH_PC(ppc), .CORE_CLK_EN(clk_en), .WAKE_CONTINUE(wake),
		.SERVICE_IRQ(svc), .REGULATOR_LOW(), .WDT_TICK(tick), .WDT_TIMEOUT(), .LF_OSC_RUN(),
		.SENSE_OSC_RUN(), .TIMER1_SLEEP_CLK(t1_sel), .TIMER1_RUN(), .CONV_RC_CLK_SEL(rc_sel),
		.CONV_RUN(), .SRC1(src1), .SRC2(src2), .RX_PENDING(rx), .TX_PENDING(tx),
		.PIN_OUT_CORE(pin_oc), .PIN_OE_N_CORE(pin_oec), .PIN_OUT(), .PIN_OE_N());
	swc_core_model i_swc_core_model (.MCLK(mclk), .SLEEP_EXEC(sleep_exec), .CLRWDT_EXEC(clrwdt),
		.PC(pc_bus), .SRC1(src1), .SRC2(src2), .PIN_OUT_CORE(pin_oc), .PIN_OE_N_CORE(pin_oec));
	function automatic logic [7:0] exp_sts(logic to, logic pd, logic sl);
		return {3'h0, to, pd, 2'h0, sl};
	endfunction
	function automatic logic [7:0] exp_f1(logic [7:0] s, logic r, logic t);
		return (s & 8'hcf) | {2'h0, r, t, 4'h0};
	endfunction
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr_reg(logic [3:0] a, logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge mclk);
		wr <= 1'h0;
	endtask
	task automatic rd_reg(logic [3:0] a, logic [7:0] e, string n);
		@(posedge mclk);
		addr <= a;
		rd <= 1'h1;
		@(posedge mclk);
		rd <= 1'h0;
		#1 chk(n, e, rdata);
	endtask
	task automatic wait_wake(logic e);
		for (int k = 0; k < 8 && wake !== 1'h1; k++) @(posedge mclk) #1;
		chk("wake", 1'h1, wake);
		chk("service", e, svc);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		reset <= 1'h0;
		rd_reg(ADDR_STATUS, exp_sts(1, 1, 0), "status");
		rd_reg(ADDR_FLAGS1, 8'h00, "flags1");
		rd_reg(4'hf, 8'h00, "unmapped");
		wr_reg(ADDR_FLAGS1, 8'hff);
		rd_reg(ADDR_FLAGS1, 8'hcf, "flags1");
		wr_reg(ADDR_FLAGS2, 8'hff);
		rd_reg(ADDR_FLAGS2, 8'hb8, "flags2");
		for (i = 0; i < 20; i++) begin
			wr_reg(ADDR_FLAGS1, 8'h00);
			wr_reg(ADDR_FLAGS2, 8'h00);
			s1 = 8'($random(seed));
			s2 = 8'($random(seed));
			wr_reg(ADDR_ENABLE1, s2);
			rx <= 1'($random(seed));
			tx <= 1'($random(seed));
			i_swc_core_model.fire(s1, s2);
			rd_reg(ADDR_FLAGS1, exp_f1(s1, rx, tx), "flags1");
			rd_reg(ADDR_FLAGS2, s2 & 8'hb8, "flags2");
		end
		rx <= 1'h0;
		tx <= 1'h0;
		wr_reg(ADDR_FLAGS1, 8'h00);
		wr_reg(ADDR_ENABLE1, 8'h01);
		for (i = 0; i < 2; i++) begin
			wr_reg(ADDR_CONTROL, i ? 8'hc2 : 8'h42);
			pc = 16'($random(seed));
			t1_sel <= 1'($random(seed));
			rc_sel <= 1'($random(seed));
			i_swc_core_model.sleep(pc);
			#1 chk("clk_en", 1'h0, clk_en);
			chk("prefetch", pc + 16'h1, ppc);
			rd_reg(ADDR_STATUS, exp_sts(1, 0, 1), "status");
			i_swc_core_model.fire(8'h01, 8'h00);
			wait_wake(i[0]);
			rd_reg(ADDR_STATUS, exp_sts(1, 0, 0), "status");
			wr_reg(ADDR_FLAGS1, 8'h00);
		end
		i_swc_core_model.clrwdt();
		i_swc_core_model.fire(8'h01, 8'h00);
		i_swc_core_model.sleep(16'h0100);
		#1 chk("clk_en", 1'h1, clk_en);
		rd_reg(ADDR_STATUS, exp_sts(1, 1, 0), "status");
		wr_reg(ADDR_FLAGS1, 8'h00);
		fork
			i_swc_core_model.sleep(16'h0200);
			i_swc_core_model.fire(8'h01, 8'h00);
		join
		wait_wake(1'h1);
		rd_reg(ADDR_STATUS, exp_sts(1, 0, 0), "status");
		wr_reg(ADDR_CONTROL, 8'h01);
		tick <= 1'h1;
		i_swc_core_model.sleep(16'h0400);
		repeat (65536) @(posedge mclk);
		wait_wake(1'h0);
		tick <= 1'h0;
		rd_reg(ADDR_STATUS, exp_sts(0, 0, 0), "status");
		for (i = 0; i < 2; i++) begin
			wr_reg(ADDR_FLAGS1, 8'h00);
			wr_reg(ADDR_CONTROL, cfg[i][15:8]);
			wr_reg(ADDR_ENABLE1, cfg[i][7:0]);
			i_swc_core_model.sleep(16'h0300);
			i_swc_core_model.fire(8'h01, 8'h00);
			repeat (8) @(posedge mclk);
			#1 chk("asleep", 1'h0, clk_en);
			@(posedge mclk) reset <= 1'h1;
			repeat (2) @(posedge mclk);
			reset <= 1'h0;
			#1 chk("clk_en", 1'h1, clk_en);
			rd_reg(ADDR_STATUS, exp_sts(1, 1, 0), "status");
		end
		close_out();
	end
	initial begin
		#3000000;
		fail_count++;
		close_out();
	end
endmodule // testbench
